// ===== design/bmc_pkg.sv
// shared constants and state codes for the bus-master memory cycle sequencer
package bmc_pkg;
  localparam int unsigned BMC_ADDR_W = 32;
  localparam int unsigned BMC_DATA_W = 32;
  localparam int unsigned BMC_WAIT_W = 3;
  localparam int unsigned BMC_LEN_W = 4;
  localparam int unsigned BMC_ACK_W = 2;
  localparam int unsigned BMC_SYNC_W = 3;
  localparam int unsigned BMC_CLK_PERIOD_NS = 8;
  // strobes are active low, so the idle level is one
  localparam logic BMC_STB_OFF = 1'b1;
  localparam logic BMC_STB_ON = 1'b0;
  // direction lines after reset show a read
  localparam logic BMC_RW_RST = 1'b1;
  localparam logic BMC_WDIR_RST = 1'b0;
  localparam logic [BMC_LEN_W-1:0] BMC_LEN_MAX = 4'hf;
  localparam logic [BMC_LEN_W-1:0] BMC_LEN_FAST = 4'h2;
  localparam logic [BMC_WAIT_W-1:0] BMC_WAIT_NONE = 3'h0;

  typedef enum logic [3:0] {
    BMC_S_IDLE = 4'b0001,
    BMC_S_T1 = 4'b0010,
    BMC_S_T2 = 4'b0100,
    BMC_S_TI = 4'b1000
  } bmc_state_e;
endpackage : bmc_pkg

// ===== design/bmc_sync.sv
// two-stage synchroniser, first stage on the falling clock edge
`timescale 1ns/1ps
module bmc_sync #(
  parameter int unsigned W = 3
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // falling-edge capture gives half a clock to settle before the second stage
  always_ff @(negedge clk or negedge rst_b)
  begin
    if (!rst_b)
      meta_q <= '1;
    else if (clk_en)
      meta_q <= d;
  end

  // second stage; only reader of meta_q
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      q <= '1;
    else if (clk_en)
      q <= meta_q;
  end
endmodule : bmc_sync

// ===== design/bmc_cycle_seq.sv
// bus-master memory cycle sequencer: strobes, wait states and termination
`timescale 1ns/1ps
// Notes on behaviour
// - in asynchronous mode memory ready passes through the synchroniser, whose first stage samples on the falling edge.
// - with no programmed waits, asynchronous ready seen in the first state ends the access in two clocks, else in three or more.
// - in the second bus mode the read/write line stays put across runs of reads or of writes.
// - the data strobe is driven only in cycles that hold at least one wait state.
// - in descriptor area work one idle clock follows the last write before a read.
// - the data bus is released at the rising edge that ends that idle clock.
// - asynchronous acknowledge ends the cycle 1.5 clocks after sampling, terminate after one.
// - wait states repeat until ready (first mode) or an acknowledge or terminate (second mode) is seen low.
// - with no programmed waits, acknowledge in the first state or terminate in the second state gives two clocks.
// - acknowledges pass through synchronisers in asynchronous mode only, terminate is sampled directly on the clock.
module bmc_cycle_seq (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic bus_ordering_select,
  input wire logic async_mode,
  input wire logic [bmc_pkg::BMC_WAIT_W-1:0] wait_states,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_descr,
  input wire logic [bmc_pkg::BMC_ADDR_W-1:0] req_addr,
  input wire logic [bmc_pkg::BMC_DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic done,
  output logic [bmc_pkg::BMC_DATA_W-1:0] rdata,
  output logic [bmc_pkg::BMC_ADDR_W-1:0] addr_out,
  output logic address_strobe_b,
  output logic early_cycle_strobe_b,
  output logic data_strobe_b,
  output logic read_write_line,
  output logic write_direction_line,
  input wire logic [bmc_pkg::BMC_DATA_W-1:0] data_in,
  output logic [bmc_pkg::BMC_DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic memory_ready_input_b,
  input wire logic [bmc_pkg::BMC_ACK_W-1:0] cycle_size_acknowledge_b,
  input wire logic sync_cycle_terminate_b
);
  import bmc_pkg::*;

  bmc_state_e state_q;
  bmc_state_e state_d;
  logic [BMC_WAIT_W-1:0] wcnt_q;
  logic wr_q;
  logic descr_q;
  logic [BMC_LEN_W-1:0] len_q;
  logic [BMC_SYNC_W-1:0] sync_in;
  logic [BMC_SYNC_W-1:0] sync_out;
  logic take;
  logic term_now;
  logic finish;

  // acknowledges and async ready share one synchroniser
  assign sync_in = {memory_ready_input_b, cycle_size_acknowledge_b};

  bmc_sync #(
    .W(BMC_SYNC_W)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .d(sync_in),
    .q(sync_out)
  );

  assign take = clk_en && req_ready && req_valid;

  // termination source per bus mode and timing mode
  always_comb
  begin
    term_now = 1'b0;
    if (!bus_ordering_select)
    begin
      if (async_mode)
        term_now = !sync_out[BMC_ACK_W];
      else
        term_now = !memory_ready_input_b;
    end
    else
    begin
      term_now = !sync_cycle_terminate_b;
      if (async_mode)
        term_now = term_now || !(&sync_out[BMC_ACK_W-1:0]);
      else
        term_now = term_now || !(&cycle_size_acknowledge_b);
    end
  end

  // programmed waits must run out before any termination counts
  assign finish = (state_q == BMC_S_T2) && (wcnt_q == BMC_WAIT_NONE) && term_now;

  // next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      BMC_S_IDLE:
      begin
        if (req_valid && req_ready)
          state_d = BMC_S_T1;
      end
      BMC_S_TI:
      begin
        state_d = (req_valid && req_ready) ? BMC_S_T1 : BMC_S_IDLE;
      end
      BMC_S_T1:
      begin
        state_d = BMC_S_T2;
      end
      BMC_S_T2:
      begin
        // wait states repeat until the cycle is terminated
        if (finish)
          state_d = (wr_q && descr_q) ? BMC_S_TI : BMC_S_IDLE;
        else
          state_d = BMC_S_T2;
      end
      default:
      begin
        state_d = BMC_S_IDLE;
      end
    endcase
  end

  // state and ready
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= BMC_S_IDLE;
      req_ready <= 1'b0;
    end
    else if (clk_en)
    begin
      state_q <= state_d;
      req_ready <= (state_d == BMC_S_IDLE) || (state_d == BMC_S_TI);
    end
  end

  // request capture
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      addr_out <= '0;
      data_out <= '0;
      wr_q <= 1'b0;
      descr_q <= 1'b0;
    end
    else if (take)
    begin
      addr_out <= req_addr;
      data_out <= req_wdata;
      wr_q <= req_write;
      descr_q <= req_descr;
    end
  end

  // programmed wait counter
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      wcnt_q <= BMC_WAIT_NONE;
    else if (take)
      wcnt_q <= wait_states;
    else if (clk_en && state_q == BMC_S_T2 && wcnt_q != BMC_WAIT_NONE)
      wcnt_q <= wcnt_q - 3'h1;
  end

  // address and early strobes; second mode holds the strobe through the cycle
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      address_strobe_b <= BMC_STB_OFF;
      early_cycle_strobe_b <= BMC_STB_OFF;
    end
    else if (take)
    begin
      address_strobe_b <= BMC_STB_ON;
      early_cycle_strobe_b <= BMC_STB_ON;
    end
    else if (clk_en && state_q == BMC_S_T1)
    begin
      address_strobe_b <= bus_ordering_select ? BMC_STB_ON : BMC_STB_OFF;
      early_cycle_strobe_b <= BMC_STB_OFF;
    end
    else if (clk_en && finish)
      address_strobe_b <= BMC_STB_OFF;
  end

  // data strobe only once the cycle has stretched past two clocks
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      data_strobe_b <= BMC_STB_OFF;
    else if (clk_en && finish)
      data_strobe_b <= BMC_STB_OFF;
    else if (clk_en && state_q == BMC_S_T2)
      data_strobe_b <= BMC_STB_ON;
  end

  // direction lines change only when a new cycle starts, never at idle
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      read_write_line <= BMC_RW_RST;
      write_direction_line <= BMC_WDIR_RST;
    end
    else if (take)
    begin
      read_write_line <= !req_write;
      write_direction_line <= req_write;
    end
  end

  // data bus drive; descriptor writes keep it through the idle clock
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      data_oe <= 1'b0;
    else if (take)
      data_oe <= req_write;
    else if (clk_en && finish)
      data_oe <= wr_q && descr_q;
    else if (clk_en && state_q == BMC_S_TI)
      data_oe <= 1'b0;
  end

  // completion pulse and read data
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      done <= 1'b0;
      rdata <= '0;
    end
    else if (clk_en)
    begin
      done <= finish;
      if (finish && !wr_q)
        rdata <= data_in;
    end
  end

  // cycle length in clocks, only the checks below read it
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      len_q <= '0;
    else if (take)
      len_q <= 4'h1;
    else if (clk_en && state_q != BMC_S_IDLE && state_q != BMC_S_TI && len_q != BMC_LEN_MAX)
      len_q <= len_q + 4'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_wait_end;
    clk_en && state_q == BMC_S_T2 && wcnt_q == BMC_WAIT_NONE;
  endsequence

  a_ds_only_wait: assert property (
    !data_strobe_b |-> len_q > BMC_LEN_FAST) else $error("data strobe in a zero-wait cycle");
  a_ready_async_end: assert property (
    s_wait_end ##0 (!bus_ordering_select && async_mode && !sync_out[BMC_ACK_W])
    |=> done && state_q != BMC_S_T2) else $error("async ready did not end the cycle");
  a_fast_two_clk: assert property (
    (done && $past(len_q) == BMC_LEN_FAST) |-> data_strobe_b) else $error("fast cycle wrong");
  a_wait_repeat: assert property (
    (clk_en && state_q == BMC_S_T2 && !term_now) |=> state_q == BMC_S_T2 && !done)
    else $error("wait state not repeated");
  a_sync_cycle_terminate_one_clk: assert property (
    s_wait_end ##0 (bus_ordering_select && !sync_cycle_terminate_b) |=> done)
    else $error("terminate did not end cycle in one clock");
  a_rw_hold_idle: assert property (
    (clk_en && !take) |=> $stable(read_write_line) && $stable(write_direction_line))
    else $error("direction line toggled outside a cycle start");
  a_idle_after_wr: assert property (
    (clk_en && finish && wr_q && descr_q) |=> state_q == BMC_S_TI ##0 data_oe)
    else $error("no idle clock after descriptor write");
  a_bus_release: assert property (
    (clk_en && state_q == BMC_S_TI && !(take && req_write)) |=> !data_oe)
    else $error("data bus not released after idle clock");
  a_ack_sync_path: assert property (
    (s_wait_end ##0 (bus_ordering_select && async_mode && sync_cycle_terminate_b
    && (&sync_out[BMC_ACK_W-1:0]))) |=> !done) else $error("raw acknowledge used in async mode");
  a_done_pulse: assert property (
    (done && clk_en) |=> !done) else $error("done longer than one clock");
endmodule : bmc_cycle_seq

// ===== test/bmc_mem_model.sv
// memory and bus slave model answering the sequencer's cycles
`timescale 1ns/1ps
module bmc_mem_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic early_cycle_strobe_b,
  input wire logic done,
  input wire logic use_ack,
  input wire logic [3:0] dly,
  input wire logic [31:0] word,
  output logic memory_ready_input_b,
  output logic [1:0] cycle_size_acknowledge_b,
  output logic sync_cycle_terminate_b,
  output logic [31:0] data_in
);
  logic busy_q;
  logic [3:0] cnt_q;
  logic hit;
  logic early;
  // track the cycle from its first state to the done pulse
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
    end
    else if (!early_cycle_strobe_b)
    begin
      busy_q <= 1'b1;
      cnt_q <= 4'h0;
    end
    else if (done)
      busy_q <= 1'b0;
    else if (busy_q)
      cnt_q <= cnt_q + 4'h1;
  end
  // answers come from flops, so they move just after a rising edge
  // dly of all ones answers already in the first state, ahead of any wait
  assign early = (dly == 4'hf);
  assign hit = ((busy_q && (early || cnt_q >= dly)) || (early && !early_cycle_strobe_b))
    && !done;
  // held low until the cycle ends; pull-ups bring lines high otherwise
  assign memory_ready_input_b = !hit;
  assign cycle_size_acknowledge_b = (hit && use_ack) ? 2'h2 : 2'h3;
  assign sync_cycle_terminate_b = !(hit && !use_ack);
  // outside a cycle the bus shows garbage, not the last word
  assign data_in = busy_q ? word : ~word;
endmodule : bmc_mem_model

// ===== test/bus_master_memory_cycle_tb.sv
// self-checking bench for the bus-master memory cycle sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR %0t got %0h exp %0h", $time, a, b); end end
module bus_master_memory_cycle_tb;
  import bmc_pkg::*;
  logic clk = 1'b0;
  logic en = 1'b1;
  logic rst_b = 1'b0;
  logic mode = 1'b0;
  logic asy = 1'b0;
  logic [2:0] ws = 3'h0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic req_descr = 1'b0;
  logic [31:0] req_addr = 32'h0;
  logic [31:0] req_wdata = 32'h0;
  logic use_ack = 1'b0;
  logic [3:0] dly = 4'h0;
  logic [31:0] word = 32'h0;
  logic req_ready, done, ecs_b, ds_b, rw, oe, rdy_b, term_b, as_b, wd;
  logic [31:0] rdata, data_in, addr, dout;
  logic [1:0] ack_b;
  int n_errors = 0;
  int num_checks = 0;
  int n;
  logic ds;
  always #4 clk = ~clk;
  bmc_cycle_seq DUT (.clk(clk), .rst_b(rst_b), .clk_en(en), .bus_ordering_select(mode),
    .async_mode(asy), .wait_states(ws), .req_valid(req_valid), .req_write(req_write),
    .req_descr(req_descr), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .done(done), .rdata(rdata), .addr_out(addr),
    .address_strobe_b(as_b), .early_cycle_strobe_b(ecs_b), .data_strobe_b(ds_b),
    .read_write_line(rw), .write_direction_line(wd), .data_in(data_in), .data_out(dout),
    .data_oe(oe), .memory_ready_input_b(rdy_b), .cycle_size_acknowledge_b(ack_b),
    .sync_cycle_terminate_b(term_b));
  bmc_mem_model MEM (.clk(clk), .rst_b(rst_b), .early_cycle_strobe_b(ecs_b), .done(done),
    .use_ack(use_ack), .dly(dly), .word(word), .memory_ready_input_b(rdy_b),
    .cycle_size_acknowledge_b(ack_b), .sync_cycle_terminate_b(term_b), .data_in(data_in));
  task automatic setup(input int m, input int a, input int w, input int u, input int d);
    @(posedge clk);
    mode <= m[0];
    asy <= a[0];
    ws <= w[2:0];
    use_ack <= u[0];
    dly <= d[3:0];
  endtask : setup
  // one transfer; n counts clocks from the take edge to the done cycle
  task automatic op(input int w, input int d, input logic [31:0] a);
    logic r;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w[0];
    req_descr <= d[0];
    req_addr <= a;
    req_wdata <= ~a;
    word <= a ^ 32'h5a5a_5a5a;
    r = 1'b0;
    while (!r)
    begin
      @(negedge clk);
      r = req_ready;
      @(posedge clk);
    end
    req_valid <= 1'b0;
    n = 0;
    ds = 1'b0;
    r = 1'b0;
    while (!r && n < 40)
    begin
      @(negedge clk);
      n++;
      r = done;
      ds = ds | !ds_b;
      `CHK(rw, !w)
      `CHK(wd, w[0])
      `CHK(addr, a)
      `CHK(ecs_b, n != 1)
      `CHK(as_b, !(n == 1 || (mode && !r)))
      `CHK(oe, r ? w[0] && d[0] : w[0])
      if (w[0]) `CHK(dout, ~a)
    end
    `CHK(r, 1'b1)
    if (!w) `CHK(rdata, a ^ 32'h5a5a_5a5a)
  endtask : op
  task automatic t_ready;
    setup(0, 0, 0, 0, 0);
    op(0, 0, 32'h100);
    `CHK(n, 3)
    `CHK(ds, 1'b0)
    setup(0, 0, 0, 0, 1);
    op(0, 0, 32'h104);
    `CHK(n, 4)
    `CHK(ds, 1'b1)
    setup(0, 0, 1, 0, 0);
    op(1, 0, 32'h108);
    `CHK(n, 4)
    $display("ready tests done");
  endtask : t_ready
  task automatic t_mode1;
    setup(1, 0, 0, 0, 0);
    op(0, 0, 32'h200);
    `CHK(n, 3)
    setup(1, 0, 0, 0, 2);
    op(1, 0, 32'h204);
    `CHK(n, 5)
    `CHK(ds, 1'b1)
    setup(1, 0, 0, 1, 0);
    op(0, 0, 32'h208);
    `CHK(n, 3)
    $display("second mode tests done");
  endtask : t_mode1
  task automatic t_async;
    setup(0, 1, 0, 0, 15);
    op(0, 0, 32'h30c);
    `CHK(n, 3)
    setup(0, 1, 0, 0, 0);
    op(0, 0, 32'h300);
    `CHK(n, 4)
    `CHK(ds, 1'b1)
    setup(1, 1, 0, 1, 0);
    op(0, 0, 32'h304);
    `CHK(n, 4)
    setup(1, 1, 0, 1, 15);
    op(0, 0, 32'h308);
    `CHK(n, 3)
    $display("async tests done");
  endtask : t_async
  task automatic t_rw;
    setup(1, 0, 0, 0, 0);
    op(0, 0, 32'h400);
    op(0, 0, 32'h404);
    op(1, 0, 32'h408);
    op(1, 0, 32'h40c);
    $display("direction tests done");
  endtask : t_rw
  task automatic t_descr;
    setup(0, 0, 0, 0, 0);
    op(1, 1, 32'h500);
    `CHK(oe, 1'b1)
    @(posedge clk);
    @(negedge clk);
    `CHK(oe, 1'b0)
    op(0, 1, 32'h504);
    `CHK(n, 3)
    $display("descriptor tests done");
  endtask : t_descr
  // a low enable holds a pending request off; the cycle runs once it rises
  task automatic t_freeze;
    setup(0, 0, 0, 0, 0);
    @(posedge clk);
    en <= 1'b0;
    req_valid <= 1'b1;
    req_write <= 1'b0;
    req_descr <= 1'b0;
    req_addr <= 32'h600;
    word <= 32'h600 ^ 32'h5a5a_5a5a;
    repeat (3)
    begin
      @(negedge clk);
      `CHK(ecs_b, 1'b1)
    end
    @(posedge clk);
    en <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    `CHK(ecs_b, 1'b0)
    repeat (2) @(negedge clk);
    `CHK(done, 1'b1)
    `CHK(rdata, 32'h600 ^ 32'h5a5a_5a5a)
    $display("enable tests done");
  endtask : t_freeze
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  // run takes about 100 clocks; this span is about thirty-seven times that
  initial
  begin
    #30000;
    n_errors++;
    stop_test();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_ready();
    t_mode1();
    t_async();
    t_rw();
    t_descr();
    t_freeze();
    stop_test();
  end
endmodule : bus_master_memory_cycle_tb
